// ===== rtl/tdmi_defs.svh
// Purpose: Constants for the test and development mode interface.
// Assumes: Included by bare name in the device, host and sync files.
// Notes: Status codes, mode-select codes and timing counts.
`ifndef TDMI_DEFS_SVH
`define TDMI_DEFS_SVH

`define TDMI_ST_HALT_STEP 3'h0
`define TDMI_ST_HOLD 3'h1
`define TDMI_ST_SYNC 3'h2
`define TDMI_ST_WAIT 3'h3
`define TDMI_ST_IRET 3'h4
`define TDMI_ST_TRAP 3'h5
`define TDMI_ST_NONSEQ 3'h6
`define TDMI_ST_EXEC 3'h7
`define TDMI_ST_ACTIVITY_BIT 2

`define TDMI_MODE_LOAD_TEST 2'h0
`define TDMI_MODE_STEP 2'h1
`define TDMI_MODE_HALT 2'h2
`define TDMI_MODE_NORMAL 2'h3

// Host clock cycles counted down after each mode-select change; changes land at least four cycles apart
`define TDMI_MODE_GAP_CYCLES 4'h3
`define TDMI_SYNC_STAGES 2

`endif

// ===== rtl/tdmi_device.sv
// Purpose: Device end: status encoder and mode-select control.
// Assumes: Execute-stage condition flags come from the core on this clock.
// Notes: Halt/step entry waits for a data access in progress to finish.
// Summary of operation
// RQ1: Status codes 000 to 111 per condition
// RQ2: Status shows previous cycle's execute stage
// RQ3: Lowest code wins among simultaneous conditions
// RQ4: Multi-cycle ops: first executing, rest hold
// RQ5: Trap: first cycle trap code, rest hold
// RQ6: Top status bit low only when idle
// RQ7: Breakpoint with busy clear: one sync cycle
// RQ8: That breakpoint otherwise changes nothing
// RQ9: Mode select: 00 load, 01 step, 10 halt, 11 normal
// RQ10: Mode select is asynchronous, synchronised first
// RQ11: Host changes one mode bit at a time
// RQ12: Host spaces mode changes over one cycle
// RQ13: Broken mode rules need processor reset; the device does not detect them and resumes on normal
// RQ14: No direct load-test to normal move
// RQ15: Test input floats every output
// RQ16: Halt/step entered in two-three cycles
// RQ17: Step to normal advances one stage
// RQ18: Two flop stages per mode bit
`timescale 1ns/10ps
`include "tdmi_defs.svh"
module tdmi_device (
  input wire logic clock,
  input wire logic rst,
  tdmi_if.device pins,
  input wire logic ex_halt_step,
  input wire logic ex_hold,
  input wire logic ex_load_test,
  input wire logic ex_wait,
  input wire logic ex_iret,
  input wire logic ex_trap,
  input wire logic ex_nonseq,
  input wire logic ex_multi_start,
  input wire logic ex_multi_busy,
  input wire logic ex_trap_busy,
  input wire logic bp_match,
  input wire logic breakpoint_busy_flag,
  input wire logic data_access_busy,
  output logic advance_pulse,
  output logic run_enable,
  output logic [1:0] mode_now
);
  tdmi_pkg::tdmi_run_state_t state_reg;
  tdmi_pkg::tdmi_run_state_t state_next;
  logic [1:0] mode_sync;
  logic [1:0] mode_prev_reg;
  logic [2:0] code_next;
  logic [2:0] status_reg;
  logic [2:0] oe_reg;
  logic test_n_meta_reg;
  logic test_n_reg;
  logic advance_next;
  logic [6:0] cond_vec;

  // Mode select is sampled as an asynchronous level
  tdmi_sync #(.WIDTH(2), .RESET_VALUE(`TDMI_MODE_NORMAL)) tdmi_sync_inst ( // RQ10 RQ18
    .clock(clock),
    .rst(rst),
    .async_in(pins.mode_select_inputs),
    .sync_out(mode_sync)
  );

  // Test pin is asynchronous as well
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      test_n_meta_reg <= 1'b1;
      test_n_reg <= 1'b1;
    end else begin
      test_n_meta_reg <= pins.test_n;
      test_n_reg <= test_n_meta_reg;
    end
  end

  function automatic logic [2:0] tdmi_encode(input logic [8:0] cond);
    logic [2:0] code;
    code = `TDMI_ST_EXEC;
    if (cond[0]) code = `TDMI_ST_HALT_STEP; // RQ3
    else if (cond[1]) code = `TDMI_ST_HOLD;
    else if (cond[2]) code = `TDMI_ST_SYNC;
    else if (cond[3]) code = `TDMI_ST_WAIT;
    else if (cond[4]) code = `TDMI_ST_IRET;
    else if (cond[5]) code = `TDMI_ST_TRAP;
    else if (cond[6]) code = `TDMI_ST_NONSEQ;
    return code;
  endfunction

  // Halt and step stop the core alike; only the way out differs
  function automatic logic tdmi_stop_mode(input logic [1:0] mode);
    logic stop;
    stop = (mode == `TDMI_MODE_HALT) || (mode == `TDMI_MODE_STEP); // RQ9
    return stop;
  endfunction

  // Hold covers the later cycles of multi-cycle ops and traps; a trap's first cycle shows the trap code, an op's first shows executing
  always_comb begin
    cond_vec = 7'h00;
    cond_vec[0] = ex_halt_step | (state_reg != tdmi_pkg::TDMI_RUN); // RQ1 RQ6
    cond_vec[1] = ex_hold | ex_multi_busy | ex_trap_busy; // RQ4 RQ5
    cond_vec[2] = ex_load_test | (bp_match & ~breakpoint_busy_flag & (state_reg == tdmi_pkg::TDMI_RUN)); // RQ7 RQ8
    cond_vec[3] = ex_wait;
    // The opening cycle of an interrupt return counts as executing, like any multi-cycle op
    cond_vec[4] = ex_iret & ~ex_multi_start & ~ex_multi_busy; // RQ4
    cond_vec[5] = ex_trap & ~ex_trap_busy; // RQ5
    cond_vec[6] = ex_nonseq;
    code_next = tdmi_encode({2'b00, cond_vec});
  end

  // Registered view: one cycle behind the execute stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status_reg <= `TDMI_ST_HALT_STEP;
    end else begin
      status_reg <= code_next; // RQ2
    end
  end

  // Enables are low in reset, so the status nets float until the first edge after release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      oe_reg <= 3'h0;
    end else begin
      oe_reg <= {3{test_n_reg}}; // RQ15
    end
  end

  assign pins.status_out = status_reg;
  assign pins.status_oe = oe_reg;

  // Run control; illegal mode sequences are not detected, so a load-test to normal move resumes like any other
  always_comb begin
    state_next = state_reg;
    advance_next = 1'b0;
    case (state_reg)
      tdmi_pkg::TDMI_RUN: begin
        if (tdmi_stop_mode(mode_sync) && !data_access_busy) begin
          state_next = tdmi_pkg::TDMI_STOPPED; // RQ16
        end
      end
      // Load test keeps the core stopped; only normal lets it go
      tdmi_pkg::TDMI_STOPPED: begin
        if (mode_sync == `TDMI_MODE_NORMAL && mode_prev_reg == `TDMI_MODE_STEP) begin
          state_next = tdmi_pkg::TDMI_STEPPING; // RQ17
          advance_next = 1'b1;
        end else if (mode_sync == `TDMI_MODE_NORMAL) begin
          state_next = tdmi_pkg::TDMI_RUN; // RQ13 RQ14
        end
      end
      // The advance lasts until any data access it began has finished
      tdmi_pkg::TDMI_STEPPING: begin
        if (!data_access_busy) begin
          state_next = tdmi_pkg::TDMI_STEP_PARKED; // RQ17
        end
      end
      // Parked after a step although the pins still read normal
      tdmi_pkg::TDMI_STEP_PARKED: begin
        if (tdmi_stop_mode(mode_sync)) begin
          state_next = tdmi_pkg::TDMI_STOPPED;
        end
      end
      default: state_next = tdmi_pkg::TDMI_RUN;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= tdmi_pkg::TDMI_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Previous synchronised mode tells the 01 to 11 step edge apart from 10 to 11
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_prev_reg <= `TDMI_MODE_NORMAL;
    end else begin
      mode_prev_reg <= mode_sync; // RQ9 RQ17
    end
  end

  // One-cycle strobe asks the core to move one pipeline stage
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      advance_pulse <= 1'b0;
    end else begin
      advance_pulse <= advance_next; // RQ17
    end
  end

  // Taken from the next state so the core stops on the same edge as the state machine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      run_enable <= 1'b1;
    end else begin
      run_enable <= (state_next == tdmi_pkg::TDMI_RUN); // RQ16
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_now <= `TDMI_MODE_NORMAL;
    end else begin
      mode_now <= mode_sync; // RQ9
    end
  end
endmodule // tdmi_device

// ===== rtl/tdmi_host.sv
// Purpose: Development system end: drives mode select, watches status.
// Assumes: Requests use a valid/ready handshake on the host clock.
// Notes: Routes illegal jumps through an intermediate mode.
`timescale 1ns/10ps
`include "tdmi_defs.svh"
module tdmi_host (
  input wire logic clock,
  input wire logic rst,
  tdmi_if.host pins,
  input wire logic req_valid,
  input wire logic [1:0] req_mode,
  input wire logic test_request,
  output logic req_ready,
  output logic [1:0] mode_driven,
  output logic [2:0] status_seen,
  output logic status_valid,
  output logic sync_seen,
  output logic activity_seen
);
  logic [1:0] target_reg;
  logic [1:0] drive_reg;
  logic [3:0] gap_reg;
  logic test_n_reg;
  logic [2:0] st_meta_reg;
  logic [2:0] st_reg;
  logic oe_meta_reg;
  logic oe_reg;
  logic [1:0] step_next;

  // One bit per step; load-test to normal detours via halt
  always_comb begin
    step_next = drive_reg;
    if (drive_reg == `TDMI_MODE_LOAD_TEST && target_reg == `TDMI_MODE_NORMAL) begin
      step_next = `TDMI_MODE_HALT; // RQ14
    end else if (drive_reg[1] != target_reg[1]) begin
      step_next = {target_reg[1], drive_reg[0]}; // RQ11
    end else if (drive_reg[0] != target_reg[0]) begin
      step_next = {drive_reg[1], target_reg[0]}; // RQ11
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      target_reg <= `TDMI_MODE_NORMAL;
      drive_reg <= `TDMI_MODE_NORMAL;
      gap_reg <= 4'h0;
      req_ready <= 1'b0;
    end else begin
      if (req_valid && req_ready) begin
        target_reg <= req_mode;
      end
      if (gap_reg != 4'h0) begin
        gap_reg <= gap_reg - 4'h1;
      end else if (step_next != drive_reg) begin
        drive_reg <= step_next;
        gap_reg <= `TDMI_MODE_GAP_CYCLES; // RQ12
      end
      req_ready <= (gap_reg == 4'h0) && (step_next == drive_reg) && !(req_valid && req_ready);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      test_n_reg <= 1'b1;
    end else begin
      test_n_reg <= ~test_request;
    end
  end

  assign pins.mode_select_inputs = drive_reg;
  assign pins.test_n = test_n_reg;

  // Status pins come from another chip
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_meta_reg <= 3'h0;
      st_reg <= 3'h0;
      oe_meta_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      st_meta_reg <= pins.status_out;
      st_reg <= st_meta_reg;
      oe_meta_reg <= &pins.status_oe;
      oe_reg <= oe_meta_reg;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_driven <= `TDMI_MODE_NORMAL;
      status_seen <= 3'h0;
      status_valid <= 1'b0;
      sync_seen <= 1'b0;
      activity_seen <= 1'b0;
    end else begin
      mode_driven <= drive_reg;
      status_seen <= st_reg;
      status_valid <= oe_reg;
      sync_seen <= oe_reg && (st_reg == `TDMI_ST_SYNC);
      activity_seen <= oe_reg && st_reg[`TDMI_ST_ACTIVITY_BIT];
    end
  end
endmodule // tdmi_host

// ===== rtl/tdmi_if.sv
// Purpose: Pins between the device end and the development system end.
// Assumes: The host qualifies status pins with the enables.
// Notes: Status pins are three-state, floated under test.
`timescale 1ns/10ps
interface tdmi_if;
  logic [1:0] mode_select_inputs;
  logic [2:0] status_out;
  logic [2:0] status_oe;
  logic test_n;

  modport device (
    input mode_select_inputs,
    input test_n,
    output status_out,
    output status_oe
  );

  modport host (
    output mode_select_inputs,
    output test_n,
    input status_out,
    input status_oe
  );
endinterface // tdmi_if

// ===== rtl/tdmi_pkg.sv
// Purpose: Types for the test and development mode interface.
// Assumes: Nothing beyond the defs header.
// Notes: No constants live here.
package tdmi_pkg;
  typedef enum logic [1:0] {
    TDMI_LOAD_TEST,
    TDMI_STEP,
    TDMI_HALT,
    TDMI_NORMAL
  } tdmi_mode_t;

  typedef enum logic [1:0] {
    TDMI_RUN,
    TDMI_STOPPED,
    TDMI_STEPPING,
    TDMI_STEP_PARKED
  } tdmi_run_state_t;
endpackage

// ===== rtl/tdmi_sync.sv
// Purpose: Two-flop synchroniser for a bus of asynchronous levels.
// Assumes: Each bit changes at most once per two destination cycles.
// Notes: The first stage feeds only the second.
`timescale 1ns/10ps
`include "tdmi_defs.svh"
module tdmi_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("tdmi_sync: WIDTH must be at least 1");
  end

  generate
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          meta_reg[i] <= RESET_VALUE[i];
          sync_out[i] <= RESET_VALUE[i];
        end else begin
          meta_reg[i] <= async_in[i];
          sync_out[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule // tdmi_sync

// ===== tb/tb_test_development_mode_interface.sv
// Purpose: Self-checking bench joining both ends.
// Assumes: 50 ns clock, inputs driven on the falling edge.
// Notes: Status expectations come from exp_status.
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h want %h", $time, g, e); end end
module tb_test_development_mode_interface;
  logic clock = 0, rst = 1, busy = 0, req_valid = 0, test_request = 0;
  logic [11:0] ex = '0, want_h = '0;
  logic [11:0] corner [6] = '{12'h000, 12'h400, 12'hC00, 12'h080, 12'h090, 12'hFFF};
  logic [1:0] req_mode = 2'h3, mode_now, mode_driven;
  logic req_ready, advance_pulse, run_enable, status_valid, sync_seen, activity_seen;
  logic [2:0] want, status_seen;
  logic [3:0] pulses;
  int failures = 0, tests_run = 0, cycles = 0, n;
  tdmi_if pins_if();
  tdmi_device tdmi_device_inst (.clock(clock), .rst(rst), .pins(pins_if), .ex_halt_step(ex[0]),
    .ex_hold(ex[1]), .ex_load_test(ex[2]), .ex_wait(ex[3]), .ex_iret(ex[4]), .ex_trap(ex[5]),
    .ex_nonseq(ex[6]), .ex_multi_start(ex[7]), .ex_multi_busy(ex[8]), .ex_trap_busy(ex[9]),
    .bp_match(ex[10]), .breakpoint_busy_flag(ex[11]), .data_access_busy(busy),
    .advance_pulse(advance_pulse), .run_enable(run_enable), .mode_now(mode_now));
  tdmi_host tdmi_host_inst (.clock(clock), .rst(rst), .pins(pins_if), .req_valid(req_valid),
    .req_mode(req_mode), .test_request(test_request), .req_ready(req_ready),
    .mode_driven(mode_driven), .status_seen(status_seen), .status_valid(status_valid), .sync_seen(sync_seen),
    .activity_seen(activity_seen));
  tdmi_properties tdmi_properties_inst (.clock(clock), .rst(rst),
    .mode_select_inputs(pins_if.mode_select_inputs), .status_out(pins_if.status_out),
    .status_oe(pins_if.status_oe), .test_n(pins_if.test_n));
  initial begin
    forever #25 clock = ~clock;
  end
  function automatic logic [2:0] exp_status(logic [11:0] e);
    if (e[0]) return 3'h0;
    if (e[1] | e[8] | e[9]) return 3'h1;
    if (e[2] | (e[10] & !e[11])) return 3'h2;
    if (e[3]) return 3'h3;
    if (e[4] & !e[7]) return 3'h4;
    if (e[5]) return 3'h5;
    if (e[6]) return 3'h6;
    return 3'h7;
  endfunction
  task end_sim();
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Sparse random conditions so every priority level wins now and then
  task run_status();
    for (int i = 0; i < 300; i++) begin
      @(negedge clock);
      if (i > 0) begin
        `CHK(pins_if.status_out, want)
        `CHK(pins_if.status_out[2], want > 3'h3)
      end
      if (i > 3) begin
        `CHK(status_seen, want_h[11:9])
        `CHK(sync_seen, want_h[11:9] == 3'h2)
        `CHK(activity_seen, want_h[11])
        `CHK(status_valid, 1'b1)
      end
      ex = (i < 6) ? corner[i] : 12'($urandom & $urandom & $urandom);
      want = exp_status(ex);
      want_h = {want_h[8:0], want};
    end
    @(negedge clock);
    `CHK(pins_if.status_out, want)
    ex = '0;
  endtask
  task set_mode(input logic [1:0] m);
    @(negedge clock);
    req_valid = 1;
    req_mode = m;
    n = 0;
    while (!req_ready && n < 50) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 0;
    n = 0;
    while (mode_driven !== m && n < 50) begin
      @(negedge clock);
      n++;
    end
    repeat (8) @(negedge clock);
    `CHK(pins_if.mode_select_inputs, m)
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    n = $urandom(32'h472A239A);
    repeat (4) @(negedge clock);
    rst = 0;
    repeat (3) @(negedge clock);
    `CHK(pins_if.status_oe, 3'h7)
    run_status();
    `CHK(run_enable, 1'b1)
    set_mode(2'h2);
    `CHK(mode_now, 2'h2)
    `CHK(run_enable, 1'b0)
    set_mode(2'h0);
    `CHK(mode_now, 2'h0)
    set_mode(2'h3);
    `CHK(mode_now, 2'h3)
    `CHK(run_enable, 1'b1)
    busy = 1;
    set_mode(2'h1);
    `CHK(run_enable, 1'b1)
    busy = 0;
    repeat (4) @(negedge clock);
    `CHK(run_enable, 1'b0)
    `CHK(mode_now, 2'h1)
    pulses = '0;
    fork
      set_mode(2'h3);
      repeat (30) @(negedge clock) pulses = pulses + 4'(advance_pulse);
    join
    `CHK(pulses, 4'h1)
    `CHK(run_enable, 1'b0)
    set_mode(2'h2);
    set_mode(2'h3);
    `CHK(run_enable, 1'b1)
    test_request = 1;
    repeat (8) @(negedge clock);
    `CHK(pins_if.test_n, 1'b0)
    `CHK(pins_if.status_oe, 3'h0)
    `CHK(status_valid, 1'b0)
    test_request = 0;
    repeat (8) @(negedge clock);
    `CHK(pins_if.status_oe, 3'h7)
    `CHK(status_valid, 1'b1)
    set_mode(2'h2);
    rst = 1;
    @(negedge clock);
    rst = 0;
    @(negedge clock);
    `CHK(mode_now, 2'h3)
    `CHK(run_enable, 1'b1)
    end_sim();
  end
endmodule // tb_test_development_mode_interface

// ===== tb/tdmi_properties.sv
// Purpose: Pin-level checks between the two ends.
// Assumes: Inputs come straight from tdmi_if.
// Notes: Core conditions are judged by the bench.
`timescale 1ns/10ps
module tdmi_properties (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] mode_select_inputs,
  input wire logic [2:0] status_out,
  input wire logic [2:0] status_oe,
  input wire logic test_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_halt_held;
    (mode_select_inputs == 2'h2 && test_n)[*8];
  endsequence
  property p_one_bit;
    $countones(mode_select_inputs ^ $past(mode_select_inputs)) <= 1;
  endproperty
  property p_gap;
    $changed(mode_select_inputs) |=> $stable(mode_select_inputs)[*2];
  endproperty
  property p_no_jump;
    $past(mode_select_inputs) == 2'h0 |-> mode_select_inputs != 2'h3;
  endproperty
  property p_float;
    $fell(test_n) |-> ##[1:3] status_oe == 3'h0;
  endproperty
  property p_float_hold;
    (!test_n)[*4] |-> status_oe == 3'h0;
  endproperty
  property p_drive;
    test_n[*6] |-> status_oe == 3'h7;
  endproperty
  property p_release;
    $fell(rst) |-> mode_select_inputs == 2'h3 && test_n;
  endproperty
  // Data access held off during halt tests, so eight cycles cover sync and entry
  property p_halt_status;
    s_halt_held |-> status_out == 3'h0;
  endproperty
  a_one_bit: assert property (p_one_bit) else $error("two mode bits changed");
  a_gap: assert property (p_gap) else $error("mode changes too close");
  a_no_jump: assert property (p_no_jump) else $error("load test went to normal");
  a_float: assert property (p_float) else $error("status not floated");
  a_float_hold: assert property (p_float_hold) else $error("status driven in test");
  a_drive: assert property (p_drive) else $error("status not driven");
  a_release: assert property (p_release) else $error("bad pins after reset");
  a_halt_status: assert property (p_halt_status) else $error("halt not shown");
endmodule // tdmi_properties
